/* File: cpsd_pkg.sv */
// package: constants and carriers for the coprocessor-select bus cycle generator
package cpsd_pkg;

  // ==========================================================
  // cycle encodings seen by the select decoder
  localparam logic [2:0] FC_CPU_SPACE   = 3'h7;  // cpu space, full decode value
  localparam logic [2:0] FC_USER_DATA   = 3'h1;  // ordinary data space
  localparam logic [2:0] FC_IDLE        = 3'h0;  // parked value between cycles
  localparam logic [3:0] CP_ACCESS_TYPE = 4'h2;  // cpu space type: coprocessor
  localparam logic [2:0] DEFAULT_IDENT  = 3'h1;  // usual floating-point identifier
  localparam int         MAX_COPROC     = 7;     // coprocessors on one bus

  // ==========================================================
  // address field positions
  localparam int TYPE_LSB  = 16;  // space type field, bits 19..16
  localparam int IDENT_LSB = 13;  // identifier field, bits 15..13
  localparam int REG_W     = 13;  // coprocessor register offset, bits 12..0

  // ==========================================================
  // timing and reset values
  localparam int          CORE_CLK_MHZ  = 100;
  localparam int          BUS_CLK_MHZ   = 25;   // bus clock driven to the system
  localparam int          HALF_CYCLES   = CORE_CLK_MHZ / (2 * BUS_CLK_MHZ);
  localparam logic [7:0]  HALF_CNT_LAST = 8'(HALF_CYCLES - 1);
  localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        coproc;   // cpu-space coprocessor access when set
    logic [2:0]  ident;    // target coprocessor identifier
    logic [31:0] addr;     // full address, or register offset in low bits
    logic        write;
    logic [31:0] wdata;
  } cpsd_req_t;

  typedef struct packed {
    logic [2:0]  function_code;
    logic [31:0] addr;
    logic        addr_strobe_n;
    logic        data_strobe_n;
    logic        read_not_write;
    logic        data_oe;
    logic [31:0] data;
  } cpsd_bus_t;

  typedef enum logic [5:0] {
    CPSD_IDLE   = 6'h01,
    CPSD_ADDR   = 6'h02,
    CPSD_LATE   = 6'h04,
    CPSD_STROBE = 6'h08,
    CPSD_WAIT   = 6'h10,
    CPSD_GAP    = 6'h20
  } cpsd_state_t;

endpackage

/* File: cpsd_host.sv */
// host bus cycle generator that drives the coprocessor select decoder and coprocessors
// ==========================================================
// Notes on behaviour
// [RULE_01] decoder uses function code and address 19..13
// [RULE_02] cpu space is function code all ones
// [RULE_03] address 19..16 equal 2 means coprocessor access
// [RULE_04] address 15..13 carry identifier, default one
// [RULE_05] up to seven coprocessors share the bus
// [RULE_06] single coprocessor may use reduced decode
// [RULE_07] select decode is combinational, not registered
// [RULE_08] late address strobe costs one wait state
// [RULE_09] host performs transfers on ordinary bus cycles
// [RULE_10] 32-bit coprocessor: low address, size tied high
// [RULE_11] host and coprocessor clocks may differ
// [RULE_12] select drops before next access strobes assert
// [RULE_13] select ORs clock-low, strobe, delayed-clock terms
// [RULE_14] select active low, idle on any mismatch
`timescale 1ns/100ps
module cpsd_host
  import cpsd_pkg::*;
#(
  parameter logic [2:0] IDENT_DFLT = DEFAULT_IDENT
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // user command side
  input  wire logic        req_valid_i,
  input  cpsd_req_t        req_i,
  input  wire logic        late_strobe_i,
  output logic             req_ready_o,
  output logic             done_o,
  output logic             bus_err_o,
  output logic [31:0]      rdata_o,
  // system bus side
  output logic             bus_clk_o,
  output logic             delayed_clock_o,
  output logic [2:0]       function_code_o,
  output logic [31:0]      addr_o,
  output logic             addr_strobe_n_o,
  output logic             data_strobe_n_o,
  output logic             read_not_write_o,
  output logic [31:0]      data_o,
  output logic             data_oe_o,
  input  wire logic [31:0] data_i,
  input  wire logic        dsack_n_i,
  input  wire logic        berr_n_i,
  output logic             coproc_addr0_o,
  output logic             coproc_size_o
);

  // ==========================================================
  // input synchronisers: coprocessor may run on any clock
  logic [1:0]  dsack_meta;
  logic [1:0]  berr_meta;
  logic [31:0] data_meta;
  logic [31:0] data_sync;
  logic        dsack_seen;
  logic        berr_seen;

  // acknowledge is asynchronous, so two flops before any use [RULE_11]
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dsack_meta <= 2'h3;
      berr_meta  <= 2'h3;
      data_meta  <= 32'h0;
      data_sync  <= 32'h0;
    end else begin
      dsack_meta <= {dsack_meta[0], dsack_n_i};
      berr_meta  <= {berr_meta[0], berr_n_i};
      data_meta  <= data_i;
      data_sync  <= data_meta;
    end
  end
  assign dsack_seen = ~dsack_meta[1];
  assign berr_seen  = ~berr_meta[1];

  // ==========================================================
  // bus clock divider and its delayed copy
  logic [7:0] half_cnt;
  logic [7:0] next_half_cnt;
  logic       tick;
  logic       bus_clk;
  logic       next_bus_clk;
  logic       dly_clk;
  logic       next_dly_clk;

  // tick marks each bus clock edge; delayed copy lags one core cycle [RULE_13]
  always_comb begin
    tick          = (half_cnt == HALF_CNT_LAST);
    next_half_cnt = tick ? 8'h0 : half_cnt + 8'h1;
    next_bus_clk  = tick ? ~bus_clk : bus_clk;
    next_dly_clk  = bus_clk;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      half_cnt <= 8'h0;
      bus_clk  <= 1'b1;
      dly_clk  <= 1'b1;
    end else begin
      half_cnt <= next_half_cnt;
      bus_clk  <= next_bus_clk;
      dly_clk  <= next_dly_clk;
    end
  end

  // ==========================================================
  // bus cycle sequencer
  cpsd_state_t state;
  cpsd_state_t next_state;
  cpsd_bus_t   bus;
  cpsd_bus_t   next_bus;
  logic        ready;
  logic        next_ready;
  logic        done;
  logic        next_done;
  logic        berr;
  logic        next_berr;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [31:0] cp_addr;

  // coprocessor cycle address: type, identifier 1..7, offset [RULE_03] [RULE_04] [RULE_05]
  always_comb begin
    cp_addr = 32'h0;
    cp_addr[TYPE_LSB +: 4]  = CP_ACCESS_TYPE;
    cp_addr[IDENT_LSB +: 3] = (req_i.ident == 3'h0) ? IDENT_DFLT : req_i.ident;
    cp_addr[REG_W-1:0]      = req_i.addr[REG_W-1:0];
  end

  // edges of the sequence fall on bus clock ticks only
  always_comb begin
    next_state = state;
    next_bus   = bus;
    next_ready = 1'b0;
    next_done  = 1'b0;
    next_berr  = 1'b0;
    next_rdata = rdata;
    unique case (state)
      CPSD_IDLE: begin
        next_ready = 1'b1;
        // start only while the bus clock is high so the address strobe falls at clock rise and the data strobe at clock fall
        if (req_valid_i && ready && tick && bus_clk) begin
          next_ready             = 1'b0;
          next_bus.read_not_write = ~req_i.write;
          next_bus.data          = req_i.wdata;
          if (req_i.coproc) begin
            // full code and type field, so a reduced two-bit decoder also matches [RULE_06]
            next_bus.function_code = FC_CPU_SPACE; // [RULE_02] [RULE_09]
            next_bus.addr          = cp_addr;      // [RULE_01]
          end else begin
            next_bus.function_code = FC_USER_DATA; // no select match [RULE_14]
            next_bus.addr          = req_i.addr;
          end
          next_state = CPSD_ADDR;
        end
      end
      CPSD_ADDR: begin
        if (tick) begin
          if (late_strobe_i) begin
            next_state = CPSD_LATE;  // strobe misses clock low [RULE_08]
          end else begin
            next_bus.addr_strobe_n = 1'b0;
            next_bus.data_oe       = ~bus.read_not_write;
            next_state             = CPSD_STROBE;
          end
        end
      end
      CPSD_LATE: begin
        // one whole bus clock of wait, so the strobe keeps its usual phase [RULE_08]
        if (tick && !bus_clk) begin
          next_bus.addr_strobe_n = 1'b0;
          next_bus.data_oe       = ~bus.read_not_write;
          next_state             = CPSD_STROBE;
        end
      end
      CPSD_STROBE: begin
        if (tick) begin
          next_bus.data_strobe_n = 1'b0;
          next_state             = CPSD_WAIT;
        end
      end
      CPSD_WAIT: begin
        // wait states last until the coprocessor acknowledges or signals a bus error
        if (tick && (dsack_seen || berr_seen)) begin
          next_bus.addr_strobe_n = 1'b1;
          next_bus.data_strobe_n = 1'b1;
          next_bus.data_oe       = 1'b0;
          next_done              = 1'b1;
          next_berr              = berr_seen;
          next_rdata             = bus.read_not_write ? data_sync : rdata;
          next_state             = CPSD_GAP;
        end
      end
      CPSD_GAP: begin
        // park fc and address so the select drops before any next strobe [RULE_12]
        if (tick) begin
          next_bus.function_code = FC_IDLE;
          next_bus.addr          = ADDR_RESET;
          next_state             = CPSD_IDLE;
        end
      end
      default: begin
        next_state = CPSD_IDLE;
        next_bus   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state                  <= CPSD_IDLE;
      bus.function_code      <= FC_IDLE;
      bus.addr               <= ADDR_RESET;
      bus.addr_strobe_n      <= 1'b1;
      bus.data_strobe_n      <= 1'b1;
      bus.read_not_write     <= 1'b1;
      bus.data_oe            <= 1'b0;
      bus.data               <= 32'h0;
      ready                  <= 1'b0;
      done                   <= 1'b0;
      berr                   <= 1'b0;
      rdata                  <= 32'h0;
    end else begin
      state <= next_state;
      bus   <= next_bus;
      ready <= next_ready;
      done  <= next_done;
      berr  <= next_berr;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // outputs, all straight from flops; the select built from them stays unclocked [RULE_07]
  assign req_ready_o      = ready;
  assign done_o           = done;
  assign bus_err_o        = berr;
  assign rdata_o          = rdata;
  assign bus_clk_o        = bus_clk;   // decoder term one uses its low phase [RULE_13]
  assign delayed_clock_o  = dly_clk;   // decoder term three [RULE_13]
  assign function_code_o  = bus.function_code;
  assign addr_o           = bus.addr;
  assign addr_strobe_n_o  = bus.addr_strobe_n;  // decoder term two [RULE_13]
  assign data_strobe_n_o  = bus.data_strobe_n;
  assign read_not_write_o = bus.read_not_write;
  assign data_o           = bus.data;
  assign data_oe_o        = bus.data_oe;

  // full-width port strap for every coprocessor on the bus [RULE_10]
  logic straps;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      straps <= 1'b1;
    end else begin
      straps <= 1'b1;
    end
  end
  assign coproc_addr0_o = straps;
  assign coproc_size_o  = straps;

endmodule

/* File: cpsd_host_chk.sv */
// checker: bus cycle order and field relations of the host cycle generator
`timescale 1ns/100ps
module cpsd_host_chk
  import cpsd_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        bus_clk_o,
  input wire logic        delayed_clock_o,
  input wire logic        req_ready_o,
  input wire logic        done_o,
  input wire logic [2:0]  function_code_o,
  input wire logic [31:0] addr_o,
  input wire logic        addr_strobe_n_o,
  input wire logic        data_strobe_n_o,
  input wire logic        read_not_write_o,
  input wire logic        data_oe_o,
  input wire logic        coproc_addr0_o,
  input wire logic        coproc_size_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // address strobe stays off long enough for the old select to drop
  sequence strobe_quiet;
    addr_strobe_n_o [*4];
  endsequence
  chk_strobe_gap: assert property ($rose(addr_strobe_n_o) |-> strobe_quiet)
    else $error("address strobe back too soon");
  chk_ds_after_as: assert property ($fell(data_strobe_n_o) |->
    !addr_strobe_n_o && !$past(addr_strobe_n_o, 2)) else $error("data strobe order");
  chk_cp_fields: assert property (!addr_strobe_n_o && function_code_o == FC_CPU_SPACE |->
    addr_o[19:16] == CP_ACCESS_TYPE && addr_o[15:13] != 3'h0) else $error("cp address");
  chk_addr_hold: assert property (!addr_strobe_n_o |=>
    addr_strobe_n_o || $stable(addr_o) && $stable(function_code_o)) else $error("addr moved");
  chk_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  chk_done_release: assert property (done_o |-> addr_strobe_n_o && data_strobe_n_o)
    else $error("strobes held at done");
  chk_ready_idle: assert property (req_ready_o |-> addr_strobe_n_o && function_code_o == FC_IDLE)
    else $error("ready outside idle");
  chk_oe_write: assert property (data_oe_o |-> !read_not_write_o && !addr_strobe_n_o)
    else $error("data driven on read");
  chk_tied_high: assert property (coproc_addr0_o && coproc_size_o)
    else $error("width straps low");
  // ==========
  // bus clock halves last two core cycles; delayed copy lags by one
  sequence bus_clk_hold_flip;
    $stable(bus_clk_o) ##1 $changed(bus_clk_o);
  endsequence
  chk_bus_clk_rate: assert property ($changed(bus_clk_o) |=> bus_clk_hold_flip)
    else $error("bus clock rate wrong");
  chk_clk_delay: assert property (delayed_clock_o == $past(bus_clk_o))
    else $error("delayed clock lag wrong");
endmodule

bind cpsd_host cpsd_host_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .bus_clk_o(bus_clk_o), .delayed_clock_o(delayed_clock_o),
  .req_ready_o(req_ready_o), .done_o(done_o), .function_code_o(function_code_o),
  .addr_o(addr_o), .addr_strobe_n_o(addr_strobe_n_o), .data_strobe_n_o(data_strobe_n_o),
  .read_not_write_o(read_not_write_o), .data_oe_o(data_oe_o),
  .coproc_addr0_o(coproc_addr0_o), .coproc_size_o(coproc_size_o));

/* File: cpsd_copro_model.sv */
// select decoder plus seven responding coprocessors and plain memory
`timescale 1ns/100ps
module cpsd_copro_model
  import cpsd_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        bus_clk_i,
  input  wire logic        delayed_clock_i,
  input  wire logic [2:0]  function_code_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        addr_strobe_n_i,
  input  wire logic        data_strobe_n_i,
  input  wire logic        read_not_write_i,
  input  wire logic [31:0] data_i,
  input  wire logic        slow_i,
  input  wire logic        addr0_i,
  input  wire logic        size_i,
  output logic [7:1]       sel_n_o,
  output logic             dsack_n_o,
  output logic             berr_n_o,
  output logic [31:0]      data_o
);
  logic [31:0] mem [0:63];
  logic [31:0] last;
  logic [5:0]  idx;
  int          cnt;
  logic        hit;
  // ==========
  // unclocked three-term select, one per identifier
  always_comb begin
    hit = function_code_i == FC_CPU_SPACE && addr_i[19:16] == CP_ACCESS_TYPE;
    idx = {addr_i[15:13], addr_i[4:2]};
    for (int k = 1; k <= MAX_COPROC; k++) begin
      sel_n_o[k] = !(hit && addr_i[15:13] == 3'(k) &&
                     (!bus_clk_i || !addr_strobe_n_i || delayed_clock_i));
    end
    data_o = (!dsack_n_o && read_not_write_i) ? mem[idx] : ~last; // released bus toggles
  end
  // ==========
  // answer after a short or long delay; wrong straps or high memory get a bus error
  always_ff @(posedge core_clk_i) begin
    last <= rst_i ? 32'h0 : data_o;
    if (rst_i || data_strobe_n_i) begin
      cnt <= 0;
      dsack_n_o <= 1'b1;
      berr_n_o <= 1'b1;
    end else begin
      cnt <= cnt + 1;
      if (cnt == (slow_i ? 6 : 1)) begin
        if (!addr0_i || !size_i || (!hit && addr_i[31])) berr_n_o <= 1'b0;
        else dsack_n_o <= 1'b0;
        if (!read_not_write_i) mem[idx] <= data_i;
      end
    end
  end
endmodule

/* File: test_cpsd_host.sv */
// self-checking bench for the host cycle generator against the coprocessor model
`timescale 1ns/100ps
`define CHK(w, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", w, e, g); end end
module test_cpsd_host;
  import cpsd_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_valid_i = 1'b0;
  logic        late_strobe_i = 1'b0;
  logic        slow = 1'b0;
  cpsd_req_t   req_i = '0;
  logic        req_ready_o, done_o, bus_err_o, bus_clk_o, delayed_clock_o, addr_strobe_n_o;
  logic        data_strobe_n_o, read_not_write_o, data_oe_o, coproc_addr0_o, coproc_size_o;
  logic        dsack_n_i, berr_n_i, err;
  logic [2:0]  function_code_o;
  logic [31:0] addr_o, data_o, data_i, rdata_o, rd;
  logic [7:1]  sel_n, seen_sel;
  int          n_pre, n_mismatch = 0, total_checks = 0;

  cpsd_host dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .late_strobe_i(late_strobe_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .bus_err_o(bus_err_o), .rdata_o(rdata_o), .bus_clk_o(bus_clk_o),
    .delayed_clock_o(delayed_clock_o), .function_code_o(function_code_o), .addr_o(addr_o),
    .addr_strobe_n_o(addr_strobe_n_o), .data_strobe_n_o(data_strobe_n_o),
    .read_not_write_o(read_not_write_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .data_i(data_i), .dsack_n_i(dsack_n_i), .berr_n_i(berr_n_i),
    .coproc_addr0_o(coproc_addr0_o), .coproc_size_o(coproc_size_o));
  cpsd_copro_model u_cp (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_clk_i(bus_clk_o),
    .delayed_clock_i(delayed_clock_o), .function_code_i(function_code_o), .addr_i(addr_o),
    .addr_strobe_n_i(addr_strobe_n_o), .data_strobe_n_i(data_strobe_n_o),
    .read_not_write_i(read_not_write_o), .data_i(data_o), .slow_i(slow),
    .addr0_i(coproc_addr0_o), .size_i(coproc_size_o), .sel_n_o(sel_n),
    .dsack_n_o(dsack_n_i), .berr_n_o(berr_n_i), .data_o(data_i));

  // ==========
  // one transfer; notes selects seen under the strobe and cycles before it
  task automatic xfer(input logic cp, input logic [2:0] id, input logic [31:0] a,
                      input logic wr, input logic [31:0] wd);
    int   guard;
    logic as_seen;
    guard = 0;
    as_seen = 1'b0;
    seen_sel = '0;
    n_pre = 0;
    while (req_ready_o !== 1'b1 && guard < 50) begin
      @(negedge core_clk_i);
      guard++;
    end
    req_i = '{coproc: cp, ident: id, addr: a, write: wr, wdata: wd};
    req_valid_i = 1'b1;
    while (done_o !== 1'b1 && guard < 300) begin
      @(negedge core_clk_i);
      guard++;
      if (req_ready_o !== 1'b1 || function_code_o !== FC_IDLE) req_valid_i = 1'b0;
      if (addr_strobe_n_o === 1'b0) begin
        as_seen = 1'b1;
        seen_sel |= ~sel_n;
      end else if (!as_seen && function_code_o !== FC_IDLE) n_pre++;
    end
    `CHK("done", 1'b1, done_o)
    err = bus_err_o;
    rd = rdata_o;
  endtask

  // ==========
  // scenarios
  task automatic t_default_ident();
    xfer(1, 3'h0, 32'h8, 1, 32'h3f80_0001);
    `CHK("select", 7'h01, seen_sel)
    `CHK("pre strobe", 2, n_pre)
    xfer(1, 3'h1, 32'h8, 0, 32'h0);
    `CHK("rdata", 32'h3f80_0001, rd)
  endtask

  task automatic t_seven();
    for (int k = 1; k <= 7; k++) begin
      xfer(1, 3'(k), 32'h4, 1, 32'h5a00_0000 + k);
      `CHK("select", 7'(1 << (k - 1)), seen_sel)
    end
    for (int k = 7; k >= 1; k--) begin
      xfer(1, 3'(k), 32'h4, 0, 32'h0);
      `CHK("rdata", 32'h5a00_0000 + k, rd)
    end
  endtask

  // late strobe costs exactly one whole bus clock; slow answer still completes
  task automatic t_late_slow();
    late_strobe_i = 1'b1;
    slow = 1'b1;
    xfer(1, 3'h3, 32'h4, 0, 32'h0);
    `CHK("pre strobe", 6, n_pre)
    `CHK("rdata", 32'h5a00_0003, rd)
    late_strobe_i = 1'b0;
    slow = 1'b0;
  endtask

  // plain cycles right after a coprocessor one, type field alone must not select
  task automatic t_plain();
    xfer(1, 3'h2, 32'h4, 1, 32'h1111_2222);
    xfer(0, 3'h0, 32'h0002_2000, 1, 32'h0bad_0001);
    `CHK("select", 7'h00, seen_sel)
    xfer(0, 3'h0, 32'h0002_2000, 0, 32'h0);
    `CHK("rdata", 32'h0bad_0001, rd)
    xfer(0, 3'h0, 32'h8000_0000, 0, 32'h0);
    `CHK("bus error", 1'b1, err)
    `CHK("select", 7'h00, seen_sel)
    `CHK("straps", 2'b11, {coproc_addr0_o, coproc_size_o})
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========
  // clock, main sequence and watchdog
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (16) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_default_ident();
    t_seven();
    t_late_slow();
    t_plain();
    end_of_test();
  end
  initial begin
    #50us;
    n_mismatch++;
    end_of_test();
  end
endmodule
